// >>> hw/rls_regs.svh
`ifndef RLS_REGS_SVH
`define RLS_REGS_SVH

// ==========================================================
// two-wire slave address, value is arbitrary
`define RLS_DEV_ADDR         7'h2A

// ==========================================================
// register byte offsets
`define RLS_OFS_BW_C         8'h00
`define RLS_OFS_BW_D         8'h01
`define RLS_OFS_LOS_A        8'h02
`define RLS_OFS_LOS_B        8'h03
`define RLS_OFS_LOS_C        8'h04
`define RLS_OFS_LOS_D        8'h05
`define RLS_OFS_ACT_BW       8'h06
`define RLS_OFS_ACT_LOS      8'h07

// ==========================================================
// field positions
`define RLS_OVR_BIT          7
`define RLS_BW_MSB           3
`define RLS_LOS_MSB          6

// ==========================================================
// reset values
`define RLS_PROF_RST         8'h00
`define RLS_BW_PROF_RST      5'h00
`define RLS_PTR_RST          8'h00
// idle bus and open rate pins, in order scl, sda, high, low
`define RLS_PIN_RST          4'hE

// ==========================================================
// codes applied when an override bit is clear
`define RLS_BW_DEF_C_8G4     4'hC
`define RLS_BW_DEF_D_9G0     4'hE
`define RLS_LOS_DEF_A_15MV   7'h0F
`define RLS_LOS_DEF_B_18MV   7'h12
`define RLS_LOS_DEF_C_26MV   7'h1A
`define RLS_LOS_DEF_D_26MV   7'h1A

// ==========================================================
// bit counter limit of one byte
`define RLS_LAST_BIT         3'h7

`endif

// >>> hw/rls_pkg.sv
package rls_pkg;

   // ==========================================================
   // two-wire slave states
   typedef enum logic [2:0] {
      RLS_IDLE,
      RLS_ADDR,
      RLS_PTR,
      RLS_WDATA,
      RLS_ACK,
      RLS_RDATA,
      RLS_RACK
   } rls_state_t;

   // ==========================================================
   // pins sampled from outside
   typedef struct packed {
      logic scl;
      logic sda;
      logic rate_pin_high;
      logic rate_pin_low;
   } rls_pins_t;

   typedef struct packed {
      logic       bw_override;
      logic [3:0] bw_code;
   } rls_bw_prof_t;

   typedef struct packed {
      logic       los_override;
      logic [6:0] los_code;
   } rls_los_prof_t;

endpackage

// >>> hw/rls_sync.sv
`timescale 1ns/1ps

module rls_sync
   import rls_pkg::*;
#(
   parameter int              W   = 4,
   parameter logic [W-1:0]    RST = '1
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          nrst,
   // async in, synced out
   input  wire logic [W-1:0]  async_in,
   output logic      [W-1:0]  sync_out
);

   logic [W-1:0] stage1;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         stage1   <= RST;
         sync_out <= RST;
      end else begin
         stage1   <= async_in;
         sync_out <= stage1;
      end
   end

endmodule // rls_sync

// >>> hw/rls_pick.sv
`timescale 1ns/1ps

module rls_pick
   import rls_pkg::*;
#(
   parameter int W = 4
) (
   // profile register fields
   input  wire logic          override,
   input  wire logic [W-1:0]  code,
   input  wire logic [W-1:0]  fallback,
   // value in effect
   output logic      [W-1:0]  value
);

   assign value = override ? code : fallback;

endmodule // rls_pick

// >>> hw/rls_top.sv
// Contract
// RULE1 - bandwidth C override set uses its code
// RULE2 - bandwidth C override clear uses 8.4 GHz
// RULE3 - both rate pins high select bandwidth C
// RULE4 - bandwidth D override set uses its code
// RULE5 - bandwidth D override clear uses 9.0 GHz
// RULE6 - high one low zero or open selects D
// RULE7 - LOS A override set uses seven-bit code
// RULE8 - LOS A override clear uses 15 mVpp
// RULE9 - both rate pins low select LOS A
// RULE10 - LOS B override set uses seven-bit code
// RULE11 - LOS B override clear uses 18 mVpp
// RULE12 - high zero low one selects LOS B
// RULE13 - LOS C override set uses seven-bit code
// RULE14 - LOS C or D clear uses 26 mVpp
// RULE15 - both rate pins high select LOS C
// RULE16 - LOS D override set uses seven-bit code
// RULE17 - high one low zero selects LOS D
// RULE18 - read-only active bandwidth field, writes ignored
// RULE19 - read-only active LOS field, writes ignored
// RULE20 - reselect on any pin or register change
`timescale 1ns/1ps
`include "rls_regs.svh"

module rls_top
   import rls_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        nrst,
   // two-wire serial bus, open drain data
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   // rate selection pins
   input  wire logic        rate_pin_high,
   input  wire logic        rate_pin_low,
   // bandwidth codes of profiles A and B from neighbouring logic
   input  wire logic [3:0]  bw_setting_a,
   input  wire logic [3:0]  bw_setting_b,
   // settings in effect
   output logic      [3:0]  bw_select,
   output logic      [6:0]  los_select
);

   // ==========================================================
   // pin synchronisers
   rls_pins_t     pins_raw;
   rls_pins_t     pins_s;
   logic          scl_q;
   logic          sda_q;
   logic          scl_rise;
   logic          scl_fall;
   logic          bus_start;
   logic          bus_stop;
   assign pins_raw = '{scl: scl_in, sda: sda_in,
                       rate_pin_high: rate_pin_high, rate_pin_low: rate_pin_low};
   // open rate pins are pulled to high=1, low=0 on the pad
   rls_sync #(.W($bits(rls_pins_t)), .RST(`RLS_PIN_RST)) u_sync (
      .clock    (clock),
      .nrst     (nrst),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   always_ff @(posedge clock) begin
      if (!nrst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= pins_s.scl;
         sda_q <= pins_s.sda;
      end
   end

   assign scl_rise  = pins_s.scl & ~scl_q;
   assign scl_fall  = ~pins_s.scl & scl_q;
   assign bus_start = pins_s.scl & scl_q & sda_q & ~pins_s.sda;
   assign bus_stop  = pins_s.scl & scl_q & ~sda_q & pins_s.sda;

   // ==========================================================
   // slave state
   rls_state_t    state;
   rls_state_t    after_ack;
   logic [2:0]    bit_cnt;
   logic [7:0]    rx;
   logic          ack_phase;
   logic          master_ack;
   logic [7:0]    ptr;
   logic [7:0]    tx;
   logic [7:0]    rd_data;
   logic [7:0]    rx_byte;
   logic          rx_done;
   logic          ptr_take;
   logic          wr_take;
   logic          load_tx;
   assign rx_byte  = {rx[6:0], pins_s.sda};
   assign rx_done  = scl_rise && (bit_cnt == `RLS_LAST_BIT);
   assign ptr_take = (state == RLS_PTR) && rx_done;
   assign wr_take  = (state == RLS_WDATA) && rx_done;
   assign load_tx  = ((state == RLS_ACK) && scl_fall && ack_phase && (after_ack == RLS_RDATA))
                   || ((state == RLS_RACK) && scl_fall && master_ack);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state      <= RLS_IDLE;
         after_ack  <= RLS_IDLE;
         bit_cnt    <= 3'h0;
         rx         <= 8'h00;
         ack_phase  <= 1'b0;
         master_ack <= 1'b0;
      end else if (bus_start) begin
         state     <= RLS_ADDR;
         bit_cnt   <= 3'h0;
         ack_phase <= 1'b0;
      end else if (bus_stop) begin
         state     <= RLS_IDLE;
         ack_phase <= 1'b0;
      end else begin
         case (state)
            RLS_IDLE: begin
               bit_cnt <= 3'h0;
            end
            RLS_ADDR: begin
               if (scl_rise) begin
                  rx      <= rx_byte;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (rx_done) begin
                     if (rx_byte[7:1] == `RLS_DEV_ADDR) begin
                        state     <= RLS_ACK;
                        after_ack <= rx_byte[0] ? RLS_RDATA : RLS_PTR;
                     end else begin
                        state <= RLS_IDLE;
                     end
                  end
               end
            end
            RLS_PTR, RLS_WDATA: begin
               if (scl_rise) begin
                  rx      <= rx_byte;
                  bit_cnt <= bit_cnt + 3'h1;
                  if (rx_done) begin
                     state     <= RLS_ACK;
                     after_ack <= RLS_WDATA;
                  end
               end
            end
            RLS_ACK: begin
               if (scl_fall) begin
                  if (!ack_phase) begin
                     ack_phase <= 1'b1;
                  end else begin
                     ack_phase <= 1'b0;
                     state     <= after_ack;
                     bit_cnt   <= 3'h0;
                  end
               end
            end
            RLS_RDATA: begin
               if (scl_fall) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  if (bit_cnt == `RLS_LAST_BIT) begin
                     state      <= RLS_RACK;
                     master_ack <= 1'b0;
                  end
               end
            end
            RLS_RACK: begin
               if (scl_rise) begin
                  master_ack <= ~pins_s.sda;
               end
               if (scl_fall) begin
                  bit_cnt <= 3'h0;
                  state   <= master_ack ? RLS_RDATA : RLS_IDLE;
               end
            end
            default: begin
               state <= RLS_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // register pointer, advances after each byte moved
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ptr <= `RLS_PTR_RST;
      end else if (ptr_take) begin
         ptr <= rx_byte;
      end else if (wr_take || load_tx) begin
         ptr <= ptr + 8'h01;
      end
   end

   // ==========================================================
   // transmit shifter and data line drive
   always_ff @(posedge clock) begin
      if (!nrst) begin
         tx <= 8'h00;
      end else if (load_tx) begin
         tx <= rd_data;
      end else if ((state == RLS_RDATA) && scl_fall) begin
         tx <= {tx[6:0], 1'b0};
      end
   end

   // data only changes while clock is low, so start and stop are never faked
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sda_oe <= 1'b0;
      end else if (bus_start || bus_stop) begin
         sda_oe <= 1'b0;
      end else if (load_tx) begin
         sda_oe <= ~rd_data[7];
      end else if ((state == RLS_ACK) && scl_fall) begin
         sda_oe <= ~ack_phase;
      end else if ((state == RLS_RDATA) && scl_fall) begin
         sda_oe <= (bit_cnt == `RLS_LAST_BIT) ? 1'b0 : ~tx[6];
      end else if ((state == RLS_RACK) && scl_fall) begin
         sda_oe <= 1'b0;
      end
   end

   assign sda_out = 1'b0;

   // ==========================================================
   // profile registers
   rls_bw_prof_t  prof_bw_c;
   rls_bw_prof_t  prof_bw_d;
   rls_los_prof_t prof_los_a;
   rls_los_prof_t prof_los_b;
   rls_los_prof_t prof_los_c;
   rls_los_prof_t prof_los_d;
   // only the override and code bits are kept; bits 6:4 of bandwidth read zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         prof_bw_c  <= `RLS_BW_PROF_RST;
         prof_bw_d  <= `RLS_BW_PROF_RST;
         prof_los_a <= `RLS_PROF_RST;
         prof_los_b <= `RLS_PROF_RST;
         prof_los_c <= `RLS_PROF_RST;
         prof_los_d <= `RLS_PROF_RST;
      end else if (wr_take) begin
         // active fields have no write path
         if (ptr == `RLS_OFS_BW_C) begin
            prof_bw_c <= {rx_byte[`RLS_OVR_BIT], rx_byte[`RLS_BW_MSB:0]};
         end else if (ptr == `RLS_OFS_BW_D) begin
            prof_bw_d <= {rx_byte[`RLS_OVR_BIT], rx_byte[`RLS_BW_MSB:0]};
         end else if (ptr == `RLS_OFS_LOS_A) begin
            prof_los_a <= rx_byte;
         end else if (ptr == `RLS_OFS_LOS_B) begin
            prof_los_b <= rx_byte;
         end else if (ptr == `RLS_OFS_LOS_C) begin
            prof_los_c <= rx_byte;
         end else if (ptr == `RLS_OFS_LOS_D) begin
            prof_los_d <= rx_byte;
         end
      end
   end

   // ==========================================================
   // read decode, unmapped offsets read zero
   always_comb begin
      if (ptr == `RLS_OFS_BW_C) begin
         rd_data = {prof_bw_c.bw_override, 3'h0, prof_bw_c.bw_code};
      end else if (ptr == `RLS_OFS_BW_D) begin
         rd_data = {prof_bw_d.bw_override, 3'h0, prof_bw_d.bw_code};
      end else if (ptr == `RLS_OFS_LOS_A) begin
         rd_data = prof_los_a;
      end else if (ptr == `RLS_OFS_LOS_B) begin
         rd_data = prof_los_b;
      end else if (ptr == `RLS_OFS_LOS_C) begin
         rd_data = prof_los_c;
      end else if (ptr == `RLS_OFS_LOS_D) begin
         rd_data = prof_los_d;
      end else if (ptr == `RLS_OFS_ACT_BW) begin
         rd_data = {4'h0, bw_select}; // RULE18
      end else if (ptr == `RLS_OFS_ACT_LOS) begin
         rd_data = {1'b0, los_select}; // RULE19
      end else begin
         rd_data = 8'h00;
      end
   end

   // ==========================================================
   // override or fixed default per profile
   logic [3:0] eff_bw_c;
   logic [3:0] eff_bw_d;
   logic [6:0] eff_los_a;
   logic [6:0] eff_los_b;
   logic [6:0] eff_los_c;
   logic [6:0] eff_los_d;

   rls_pick #(.W(4)) u_bw_c ( // RULE1 RULE2
      .override (prof_bw_c.bw_override),
      .code     (prof_bw_c.bw_code),
      .fallback (`RLS_BW_DEF_C_8G4),
      .value    (eff_bw_c)
   );
   rls_pick #(.W(4)) u_bw_d ( // RULE4 RULE5
      .override (prof_bw_d.bw_override),
      .code     (prof_bw_d.bw_code),
      .fallback (`RLS_BW_DEF_D_9G0),
      .value    (eff_bw_d)
   );
   rls_pick #(.W(7)) u_los_a ( // RULE7 RULE8
      .override (prof_los_a.los_override),
      .code     (prof_los_a.los_code),
      .fallback (`RLS_LOS_DEF_A_15MV),
      .value    (eff_los_a)
   );
   rls_pick #(.W(7)) u_los_b ( // RULE10 RULE11
      .override (prof_los_b.los_override),
      .code     (prof_los_b.los_code),
      .fallback (`RLS_LOS_DEF_B_18MV),
      .value    (eff_los_b)
   );
   rls_pick #(.W(7)) u_los_c ( // RULE13 RULE14
      .override (prof_los_c.los_override),
      .code     (prof_los_c.los_code),
      .fallback (`RLS_LOS_DEF_C_26MV),
      .value    (eff_los_c)
   );
   rls_pick #(.W(7)) u_los_d ( // RULE16 RULE14
      .override (prof_los_d.los_override),
      .code     (prof_los_d.los_code),
      .fallback (`RLS_LOS_DEF_D_26MV),
      .value    (eff_los_d)
   );

   // ==========================================================
   // profile choice from the rate pins
   logic [3:0] next_bw_select;
   logic [6:0] next_los_select;
   always_comb begin
      case ({pins_s.rate_pin_high, pins_s.rate_pin_low})
         2'b00: begin
            next_bw_select  = bw_setting_a;
            next_los_select = eff_los_a; // RULE9
         end
         2'b01: begin
            next_bw_select  = bw_setting_b;
            next_los_select = eff_los_b; // RULE12
         end
         2'b11: begin
            next_bw_select  = eff_bw_c; // RULE3
            next_los_select = eff_los_c; // RULE15
         end
         default: begin
            // open pins read as high=1 low=0
            next_bw_select  = eff_bw_d; // RULE6
            next_los_select = eff_los_d; // RULE17
         end
      endcase
   end

   // re-evaluated every cycle, so a setting or register change lands one edge later, a rate pin change three edges later
   always_ff @(posedge clock) begin
      if (!nrst) begin
         bw_select  <= 4'h0;
         los_select <= 7'h00;
      end else begin
         bw_select  <= next_bw_select; // RULE20
         los_select <= next_los_select; // RULE20
      end
   end

endmodule // rls_top

// >>> test/rls_checker.sv
`timescale 1ns/1ps

module rls_checker
   import rls_pkg::*;
(
   // clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // bus and pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       sda_out,
   input  wire logic       sda_oe,
   input  wire logic       rate_pin_high,
   input  wire logic       rate_pin_low,
   input  wire logic [3:0] bw_setting_a,
   input  wire logic [3:0] bw_setting_b,
   // settings in effect
   input  wire logic [3:0] bw_select,
   input  wire logic [6:0] los_select
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // ==========================================================
   // helpers: quiet time of selecting inputs, run of scl high
   logic [10:0] prev;
   logic [3:0]  quiet;
   logic [3:0]  scl_hi;

   always_ff @(posedge clock) begin
      prev <= {rate_pin_high, rate_pin_low, scl_in, bw_setting_a, bw_setting_b};
   end

   always_ff @(posedge clock) begin
      if (!nrst || prev != {rate_pin_high, rate_pin_low, scl_in, bw_setting_a, bw_setting_b})
         quiet <= 4'h0;
      else if (quiet != 4'hF)
         quiet <= quiet + 4'h1;
   end

   always_ff @(posedge clock) begin
      if (!nrst || !scl_in)
         scl_hi <= 4'h0;
      else if (scl_hi != 4'hF)
         scl_hi <= scl_hi + 4'h1;
   end

   // ==========================================================
   // assertions
   // five cycles covers the pin synchroniser plus output flop
   sequence held_a; (!rate_pin_high && !rate_pin_low) [*5]; endsequence
   sequence held_b; (!rate_pin_high && rate_pin_low) [*5]; endsequence

   bw_pick_a_a: assert property (held_a |-> bw_select == $past(bw_setting_a))
      else $error("bw_select not taken from setting a");
   bw_pick_b_a: assert property (held_b |-> bw_select == $past(bw_setting_b))
      else $error("bw_select not taken from setting b");
   bw_quiet_a: assert property (quiet > 4'h5 |-> $stable(bw_select))
      else $error("bw_select moved without a cause");
   los_quiet_a: assert property (quiet > 4'h5 |-> $stable(los_select))
      else $error("los_select moved without a cause");
   oe_rise_a: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("sda_oe rose while scl high");
   oe_fall_a: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("sda_oe fell while scl high");
   oe_idle_a: assert property (scl_hi > 4'hB |-> !sda_oe)
      else $error("sda_oe held on an idle bus");
   sda_zero_a: assert property (sda_out == 1'b0)
      else $error("sda_out not zero");
endmodule // rls_checker

bind rls_top rls_checker u_chk (.clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .rate_pin_high(rate_pin_high),
   .rate_pin_low(rate_pin_low), .bw_setting_a(bw_setting_a), .bw_setting_b(bw_setting_b),
   .bw_select(bw_select), .los_select(los_select));

// >>> test/rls_master.sv
`timescale 1ns/1ps

module rls_master
   import rls_pkg::*;
(
   // clock and wire level
   input  wire logic clock,
   input  wire logic sda,
   // bus drive, sda_low pulls the line down
   output logic      scl,
   output logic      sda_low
);
   logic [7:0] buf_q [8];

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // ==========================================================
   // bit level, ten clocks a phase, changes on falling edges
   task automatic ph();
      repeat (10) @(negedge clock);
   endtask

   task automatic start();
      sda_low = 1'b0;
      ph();
      scl = 1'b1;
      ph();
      sda_low = 1'b1;
      ph();
      scl = 1'b0;
      ph();
   endtask

   task automatic stop();
      sda_low = 1'b1;
      ph();
      scl = 1'b1;
      ph();
      sda_low = 1'b0;
      ph();
   endtask

   task automatic bitx(input logic b, output logic r);
      sda_low = !b;
      ph();
      scl = 1'b1;
      ph();
      r = sda;
      scl = 1'b0;
      ph();
   endtask

   task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic got);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(last, got);
   endtask

   // ==========================================================
   // one transaction of n bytes through buf_q
   task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] ofs,
                       input int n, output logic ack);
      logic [7:0] q;
      logic       g;
      start();
      byte_x({a, 1'b0}, 1'b1, q, g);
      ack = !g;
      byte_x(ofs, 1'b1, q, g);
      ack &= !g;
      if (rd) begin
         start();
         byte_x({a, 1'b1}, 1'b1, q, g);
         ack &= !g;
      end
      for (int i = 0; i < n; i++) begin
         if (rd)
            byte_x(8'hFF, i == n - 1, buf_q[i], g);
         else begin
            byte_x(buf_q[i], 1'b1, q, g);
            ack &= !g;
         end
      end
      stop();
   endtask
endmodule // rls_master

// >>> test/tb_top.sv
`timescale 1ns/1ps
`include "rls_regs.svh"

module tb_top
   import rls_pkg::*;
;
   logic       clock, nrst, scl, sda_low, sda_out, sda_oe, pin_hi, pin_lo, ack;
   logic [3:0] bw_a, bw_b, bw_select;
   logic [6:0] los_select;
   logic [7:0] r [6];
   int         errors, n_compared, cycles;
   wire logic  sda = (sda_oe || sda_low) ? 1'b0 : 1'b1;
   logic [7:0] wv [3][6] = '{'{6{8'h00}}, '{8'hF3, 8'h85, 8'hFF, 8'h80, 8'hAA, 8'hD5},
                             '{8'h0F, 8'h0A, 8'h7F, 8'h55, 8'h01, 8'h7E}};

   rls_top dut (.clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .rate_pin_high(pin_hi), .rate_pin_low(pin_lo), .bw_setting_a(bw_a),
      .bw_setting_b(bw_b), .bw_select(bw_select), .los_select(los_select));
   rls_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

   // ==========================================================
   // compare, verdict, expectations
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [3:0] ebw(input logic [1:0] p);
      case (p)
         2'b00:   ebw = bw_a;
         2'b01:   ebw = bw_b;
         2'b11:   ebw = r[0][7] ? r[0][3:0] : `RLS_BW_DEF_C_8G4;
         default: ebw = r[1][7] ? r[1][3:0] : `RLS_BW_DEF_D_9G0;
      endcase
   endfunction

   function automatic logic [6:0] elos(input logic [1:0] p);
      case (p)
         2'b00:   elos = r[2][7] ? r[2][6:0] : `RLS_LOS_DEF_A_15MV;
         2'b01:   elos = r[3][7] ? r[3][6:0] : `RLS_LOS_DEF_B_18MV;
         2'b11:   elos = r[4][7] ? r[4][6:0] : `RLS_LOS_DEF_C_26MV;
         default: elos = r[5][7] ? r[5][6:0] : `RLS_LOS_DEF_D_26MV;
      endcase
   endfunction

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // hang guard, well above the roughly 40k cycles of the sequence
   always @(posedge clock) begin
      cycles++;
      if (cycles == 100000) begin
         errors++;
         end_sim();
      end
   end

   // ==========================================================
   // main sequence: reset values, overrides set, overrides clear
   initial begin
      nrst = 1'b0;
      pin_hi = 1'b1;
      pin_lo = 1'b0;
      bw_a = 4'h3;
      bw_b = 4'h6;
      repeat (12) @(negedge clock);
      nrst = 1'b1;
      repeat (4) @(negedge clock);
      for (int ph = 0; ph < 3; ph++) begin
         for (int i = 0; i < 6; i++) begin
            r[i] = wv[ph][i];
            m.buf_q[i] = r[i];
         end
         if (ph > 0) begin
            m.xfer(`RLS_DEV_ADDR, 1'b0, 8'h00, 6, ack);
            check("write ack", {7'h00, ack}, 8'h01);
         end
         m.xfer(`RLS_DEV_ADDR, 1'b1, 8'h00, 8, ack);
         for (int i = 0; i < 6; i++)
            check("reg readback", m.buf_q[i], r[i] & (i < 2 ? 8'h8F : 8'hFF));
         for (int p = 0; p < 4; p++) begin
            {pin_hi, pin_lo} = p[1:0];
            bw_a = bw_a + 4'h5;
            bw_b = bw_b + 4'h3;
            repeat (8) @(negedge clock);
            check("bw_select", {4'h0, bw_select}, {4'h0, ebw(p[1:0])});
            check("los_select", {1'b0, los_select}, {1'b0, elos(p[1:0])});
            m.xfer(`RLS_DEV_ADDR, 1'b1, 8'h06, 2, ack);
            check("active bw", m.buf_q[0], {4'h0, ebw(p[1:0])});
            check("active los", m.buf_q[1], {1'b0, elos(p[1:0])});
         end
      end
      // read-only places ignore writes
      m.buf_q[0] = 8'h5A;
      m.buf_q[1] = 8'h33;
      m.xfer(`RLS_DEV_ADDR, 1'b0, 8'h06, 2, ack);
      m.xfer(`RLS_DEV_ADDR, 1'b1, 8'h06, 2, ack);
      check("active bw kept", m.buf_q[0], {4'h0, ebw(2'b11)});
      check("active los kept", m.buf_q[1], {1'b0, elos(2'b11)});
      m.xfer(`RLS_DEV_ADDR, 1'b1, 8'h10, 1, ack);
      check("unmapped read", m.buf_q[0], 8'h00);
      // foreign address is refused and changes nothing
      m.buf_q[0] = 8'h8B;
      m.xfer(`RLS_DEV_ADDR ^ 7'h01, 1'b0, 8'h00, 1, ack);
      check("foreign ack", {7'h00, ack}, 8'h00);
      m.xfer(`RLS_DEV_ADDR, 1'b1, 8'h00, 1, ack);
      check("reg after foreign", m.buf_q[0], r[0] & 8'h8F);
      end_sim();
   end
endmodule // tb_top
